// >>> bench/host_port_model.sv
// host side model: index then data access on both ports
`timescale 1ns/1ps
module host_port_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  output logic o_gfx_index_wr,
  output logic o_gfx_data_wr,
  output logic o_gfx_data_rd,
  output logic o_crt_index_wr,
  output logic o_crt_data_wr,
  output logic o_crt_data_rd,
  output logic [7:0] o_wdata
);
  initial begin
    {o_gfx_index_wr, o_gfx_data_wr, o_gfx_data_rd} = 3'h0;
    {o_crt_index_wr, o_crt_data_wr, o_crt_data_rd} = 3'h0;
    o_wdata = 8'h00;
  end
  // op 0 index only, 1 write, 2 read
  task automatic xfer(input bit crt, input bit [1:0] op,
      input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(negedge i_mclk);
    o_wdata = idx;
    o_gfx_index_wr = !crt;
    o_crt_index_wr = crt;
    @(negedge i_mclk);
    o_gfx_index_wr = 1'b0;
    o_crt_index_wr = 1'b0;
    if (op != 2'h0) begin
      o_wdata = d;
      {o_crt_data_rd, o_crt_data_wr} = crt ? op : 2'h0;
      {o_gfx_data_rd, o_gfx_data_wr} = crt ? 2'h0 : op;
      @(negedge i_mclk);
      {o_crt_data_rd, o_crt_data_wr} = 2'h0;
      {o_gfx_data_rd, o_gfx_data_wr} = 2'h0;
    end
    // released bus must not show a stale byte
    o_wdata = ~o_wdata;
    q = i_rdata;
  endtask
endmodule // host_port_model

// >>> bench/vga_ext_regs_bench.sv
// self-checking bench for the extension register bank
`timescale 1ns/1ps
module vga_ext_regs_bench;
  logic i_mclk, i_reset_n, i_crt_protect, i_misc_ctrl2_std;
  logic i_misc_out_page, i_word_mode, i_graphics_mode;
  logic [1:0] i_graphics_misc_chain, i_mem_data_pins;
  logic [1:0] o_char_width, o_start_addr_hi;
  logic [19:0] i_host_addr;
  logic [17:0] i_char_address_counter;
  logic [8:0] i_config_straps;
  logic i_gfx_index_wr, i_gfx_data_wr, i_gfx_data_rd;
  logic i_crt_index_wr, i_crt_data_wr, i_crt_data_rd;
  logic [7:0] i_wdata, o_rdata, o_crt_wmask, o_misc_wmask, q;
  logic [3:0] o_mem_size, o_mem_map;
  logic o_alt_offset_en, o_host_16bit, o_rom_16bit, o_host_ma0, o_crt_ma0;
  logic o_alt_pc_display_mode, o_non_vga_crt, o_hclk_8_9, o_clk_sel2;
  logic o_clk_mux_freeze, o_display_enable_mode, o_pclk_is_video_clock_in;
  logic o_video_oe, o_mem_oe, o_legacy_compat, o_attr_write_only;
  logic o_upper_wr_en, o_upper_rd_en;
  int fail_count = 0;
  int n_checks = 0;
  // lock bits, protect, crt index, expected write mask
  logic [24:0] lock_tbl [13] = '{25'h0420000, 25'h0420752, 25'h0421000,
    25'h04217FB, 25'h04209DF, 25'h04211F0, 25'h0010000, 25'h0010710,
    25'h0050752, 25'h00110FF, 25'h00117FF, 25'h04006FF, 25'h00200FF};

  vga_ext_regs i_vga_ext_regs (.i_mclk, .i_reset_n, .i_gfx_index_wr,
    .i_gfx_data_wr, .i_gfx_data_rd, .i_crt_index_wr, .i_crt_data_wr,
    .i_crt_data_rd, .i_wdata, .o_rdata, .o_rdata_hit(), .i_crt_protect,
    .i_misc_ctrl2_std, .i_graphics_misc_chain, .i_misc_out_page,
    .i_word_mode, .i_graphics_mode, .i_host_addr, .i_char_address_counter,
    .i_mem_data_pins, .i_config_straps, .o_crt_wmask, .o_misc_wmask,
    .o_mem_size, .o_mem_map, .o_alt_offset_en, .o_host_16bit, .o_rom_16bit,
    .o_host_ma0, .o_crt_ma0, .o_alt_pc_display_mode, .o_non_vga_crt,
    .o_char_width, .o_hclk_8_9, .o_clk_sel2, .o_clk_mux_freeze,
    .o_start_addr_hi, .o_display_enable_mode, .o_pclk_is_video_clock_in, .o_video_oe,
    .o_mem_oe, .o_legacy_compat, .o_attr_write_only, .o_upper_wr_en,
    .o_upper_rd_en);

  host_port_model i_host_port_model (.i_mclk, .i_rdata(o_rdata),
    .o_gfx_index_wr(i_gfx_index_wr), .o_gfx_data_wr(i_gfx_data_wr),
    .o_gfx_data_rd(i_gfx_data_rd), .o_crt_index_wr(i_crt_index_wr),
    .o_crt_data_wr(i_crt_data_wr), .o_crt_data_rd(i_crt_data_rd),
    .o_wdata(i_wdata));

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input bit crt, input logic [7:0] idx, input logic [7:0] d);
    i_host_port_model.xfer(crt, 2'h1, idx, d, q);
  endtask

  task automatic rd(input bit crt, input logic [7:0] idx, input logic [7:0] e);
    i_host_port_model.xfer(crt, 2'h2, idx, 8'h00, q);
    chk(q, e);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard well beyond the longest sequence
  initial begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    complete_run();
  end

  initial begin
    i_reset_n = 1'b0;
    {i_crt_protect, i_misc_ctrl2_std, i_misc_out_page} = 3'h0;
    {i_word_mode, i_graphics_mode} = 2'h0;
    i_graphics_misc_chain = 2'h0;
    i_host_addr = 20'h00000;
    i_char_address_counter = 18'h00000;
    i_mem_data_pins = 2'h1;
    i_config_straps = 9'h1A5;
    repeat (3) @(negedge i_mclk);
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_mclk);
    rd(1'b0, 8'h0B, 8'h02);
    rd(1'b0, 8'h0F, 8'hA8);
    chk({o_mem_size, o_mem_map}, 8'h11);
    chk({o_video_oe, o_mem_oe, o_upper_wr_en, o_upper_rd_en}, 8'h0C);
    rd(1'b1, 8'h29, 8'hFF);
    wr(1'b0, 8'h0B, 8'hFF);
    rd(1'b0, 8'h0B, 8'h02);
    wr(1'b0, 8'h0F, 8'h05);
    rd(1'b0, 8'h0F, 8'hAD);
    $display("reset and unlock test done");
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, 8'h0B, {i[1:0], i[1:0], 4'hE});
      chk({o_mem_size, o_mem_map}, {4'h1 << i, 4'h1 << i});
    end
    chk({o_alt_offset_en, o_host_16bit, o_rom_16bit}, 8'h07);
    i_misc_ctrl2_std = 1'b1;
    @(negedge i_mclk);
    chk(o_mem_size, 8'h01);
    i_misc_ctrl2_std = 1'b0;
    i_word_mode = 1'b1;
    i_host_addr = 20'h40000;
    i_char_address_counter = 18'h20000;
    @(negedge i_mclk);
    chk({o_host_ma0, o_crt_ma0}, 8'h03);
    wr(1'b0, 8'h0B, 8'h0E);
    i_graphics_misc_chain = 2'h2;
    i_misc_out_page = 1'b1;
    i_host_addr = 20'h10001;
    @(negedge i_mclk);
    chk(o_host_ma0, 8'h00);
    i_misc_out_page = 1'b0;
    @(negedge i_mclk);
    chk(o_host_ma0, 8'h01);
    $display("memory size test done");
    i_graphics_mode = 1'b1;
    wr(1'b0, 8'h0C, 8'hDB);
    chk({o_alt_pc_display_mode, o_non_vga_crt, o_char_width}, 8'h0C);
    chk({o_hclk_8_9, o_clk_sel2, o_clk_mux_freeze}, 8'h05);
    i_graphics_mode = 1'b0;
    @(negedge i_mclk);
    chk(o_char_width, 8'h03);
    $display("video select test done");
    foreach (lock_tbl[k]) begin
      wr(1'b0, 8'h0D, lock_tbl[k][24:17]);
      i_crt_protect = lock_tbl[k][16];
      i_host_port_model.xfer(1'b1, 2'h0, lock_tbl[k][15:8], 8'h00, q);
      chk(o_crt_wmask, lock_tbl[k][7:0]);
    end
    i_crt_protect = 1'b0;
    wr(1'b0, 8'h0D, 8'hD8);
    chk(o_misc_wmask, 8'h3F);
    chk(o_start_addr_hi, 8'h03);
    wr(1'b0, 8'h0D, 8'h48);
    chk({o_misc_wmask[7:6], o_start_addr_hi}, 8'h09);
    $display("crt lock test done");
    wr(1'b0, 8'h0E, 8'hF2);
    chk({o_display_enable_mode, o_pclk_is_video_clock_in, o_video_oe, o_mem_oe},
        8'h0C);
    chk({o_legacy_compat, o_attr_write_only}, 8'h03);
    rd(1'b0, 8'h0B, 8'hFF);
    rd(1'b0, 8'h0F, 8'hFF);
    wr(1'b1, 8'h29, 8'hF5);
    chk({o_upper_wr_en, o_upper_rd_en}, 8'h03);
    rd(1'b1, 8'h29, 8'hF5);
    wr(1'b1, 8'h29, 8'h8C);
    chk({o_upper_wr_en, o_upper_rd_en}, 8'h00);
    rd(1'b1, 8'h29, 8'hFF);
    wr(1'b0, 8'h0E, 8'h00);
    rd(1'b0, 8'h0E, 8'h00);
    $display("output and upper unlock test done");
    wr(1'b0, 8'h0F, 8'h04);
    wr(1'b0, 8'h0C, 8'h00);
    chk({o_alt_pc_display_mode, o_hclk_8_9}, 8'h03);
    rd(1'b0, 8'h0F, 8'hAC);
    $display("relock test done");
    complete_run();
  end
endmodule // vga_ext_regs_bench

// >>> core/vga_ext_regs.sv
// extension configuration and group locking register bank
`timescale 1ns/1ps
module vga_ext_regs #(
  parameter int STRAPS = vga_ext_pkg::STRAP_W
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_gfx_index_wr,
  input wire logic i_gfx_data_wr,
  input wire logic i_gfx_data_rd,
  input wire logic i_crt_index_wr,
  input wire logic i_crt_data_wr,
  input wire logic i_crt_data_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rdata_hit,
  input wire logic i_crt_protect,
  input wire logic i_misc_ctrl2_std,
  input wire logic [1:0] i_graphics_misc_chain,
  input wire logic i_misc_out_page,
  input wire logic i_word_mode,
  input wire logic i_graphics_mode,
  input wire logic [19:0] i_host_addr,
  input wire logic [17:0] i_char_address_counter,
  input wire logic [1:0] i_mem_data_pins,
  input wire logic [STRAPS-1:0] i_config_straps,
  output logic [7:0] o_crt_wmask,
  output logic [7:0] o_misc_wmask,
  output logic [3:0] o_mem_size,
  output logic [3:0] o_mem_map,
  output logic o_alt_offset_en,
  output logic o_host_16bit,
  output logic o_rom_16bit,
  output logic o_host_ma0,
  output logic o_crt_ma0,
  output logic o_alt_pc_display_mode,
  output logic o_non_vga_crt,
  output logic [1:0] o_char_width,
  output logic o_hclk_8_9,
  output logic o_clk_sel2,
  output logic o_clk_mux_freeze,
  output logic [1:0] o_start_addr_hi,
  output logic o_display_enable_mode,
  output logic o_pclk_is_video_clock_in,
  output logic o_video_oe,
  output logic o_mem_oe,
  output logic o_legacy_compat,
  output logic o_attr_write_only,
  output logic o_upper_wr_en,
  output logic o_upper_rd_en
);
  logic [7:0] gfx_index_q;
  logic [7:0] crt_index_q;
  logic [7:0] memory_size_reg_q;
  logic [7:0] video_select_reg_q;
  logic [7:0] crt_lock_reg_q;
  logic [7:0] video_output_ctrl_reg_q;
  logic [2:0] lower_unlock_reg_q;
  logic [7:0] upper_unlock_reg_q;
  logic [1:0] md_meta_q;
  logic [1:0] md_sync_q;
  logic [STRAPS-1:0] cnf_meta_q;
  logic [STRAPS-1:0] cnf_sync_q;
  logic [2:0] strap_stage_q;
  logic lower_wr_ok;
  logic lower_rd_ok;
  logic gfx_wr;
  logic [7:0] rdata_d;
  logic rd_hit_d;

  // index ports first, data port accesses use the stored index
  // index then data
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gfx_index_q <= vga_ext_pkg::RESET_VALUE;
      crt_index_q <= vga_ext_pkg::RESET_VALUE;
    end else begin
      if (i_gfx_index_wr) begin
        gfx_index_q <= i_wdata;
      end
      if (i_crt_index_wr) begin
        crt_index_q <= i_wdata;
      end
    end
  end

  // pins are asynchronous: two stages before anything looks at them
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      md_meta_q <= 2'h0;
      md_sync_q <= 2'h0;
      cnf_meta_q <= '0;
      cnf_sync_q <= '0;
    end else begin
      md_meta_q <= i_mem_data_pins;
      md_sync_q <= md_meta_q;
      cnf_meta_q <= i_config_straps;
      cnf_sync_q <= cnf_meta_q;
    end
  end

  assign lower_wr_ok = (lower_unlock_reg_q == vga_ext_pkg::UNLOCK_CODE);
  assign lower_rd_ok = !video_output_ctrl_reg_q[vga_ext_pkg::VO_LEGACY];
  assign gfx_wr = i_gfx_data_wr && lower_wr_ok;

  // strap capture waits until the second sync stage holds the pins
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_stage_q <= 3'h0;
    end else begin
      strap_stage_q <= {strap_stage_q[1:0], 1'b1};
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      memory_size_reg_q <= vga_ext_pkg::RESET_VALUE;
    end else if (strap_stage_q[1] && !strap_stage_q[2]) begin
      memory_size_reg_q[1:0] <= ~md_sync_q;
    end else if (gfx_wr && gfx_index_q == vga_ext_pkg::IDX_MEM_SIZE) begin
      memory_size_reg_q <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      video_select_reg_q <= vga_ext_pkg::RESET_VALUE;
      crt_lock_reg_q <= vga_ext_pkg::RESET_VALUE;
      video_output_ctrl_reg_q <= vga_ext_pkg::RESET_VALUE;
    end else if (gfx_wr) begin
      if (gfx_index_q == vga_ext_pkg::IDX_VID_SEL) begin
        video_select_reg_q <= i_wdata;
      end else if (gfx_index_q == vga_ext_pkg::IDX_CRT_LOCK) begin
        crt_lock_reg_q <= i_wdata;
      end else if (gfx_index_q == vga_ext_pkg::IDX_VID_OUT) begin
        video_output_ctrl_reg_q <= i_wdata;
      end
    end
  end

  // unlock registers themselves are always writable, else no way back in
  // unlock persists
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lower_unlock_reg_q <= 3'h0;
    end else if (i_gfx_data_wr &&
                 gfx_index_q == vga_ext_pkg::IDX_LOW_UNLOCK) begin
      lower_unlock_reg_q <= i_wdata[2:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      upper_unlock_reg_q <= vga_ext_pkg::RESET_VALUE;
    end else if (i_crt_data_wr &&
                 crt_index_q == vga_ext_pkg::IDX_UP_UNLOCK) begin
      upper_unlock_reg_q <= i_wdata;
    end
  end

  assign o_upper_wr_en = (upper_unlock_reg_q[2:0] == vga_ext_pkg::UNLOCK_CODE);
  assign o_upper_rd_en = upper_unlock_reg_q[vga_ext_pkg::RD_EN_BIT] &&
                         !upper_unlock_reg_q[vga_ext_pkg::RD_BLK_BIT];

  // read mux, answered one cycle after the strobe
  always_comb begin
    rdata_d = vga_ext_pkg::RESET_VALUE;
    rd_hit_d = 1'b0;
    if (i_gfx_data_rd && gfx_index_q >= vga_ext_pkg::IDX_MEM_SIZE &&
        gfx_index_q <= vga_ext_pkg::IDX_LOW_UNLOCK) begin
      rd_hit_d = 1'b1;
      if (!lower_rd_ok) begin
        rdata_d = vga_ext_pkg::PROTECTED_READ;
      end else if (gfx_index_q == vga_ext_pkg::IDX_MEM_SIZE) begin
        rdata_d = memory_size_reg_q;
      end else if (gfx_index_q == vga_ext_pkg::IDX_VID_SEL) begin
        rdata_d = video_select_reg_q;
      end else if (gfx_index_q == vga_ext_pkg::IDX_CRT_LOCK) begin
        rdata_d = crt_lock_reg_q;
      end else if (gfx_index_q == vga_ext_pkg::IDX_VID_OUT) begin
        rdata_d = video_output_ctrl_reg_q;
      end else begin
        rdata_d = {cnf_sync_q[7], cnf_sync_q[6], cnf_sync_q[5],
                   cnf_sync_q[4], cnf_sync_q[8], lower_unlock_reg_q};
      end
    end else if (i_crt_data_rd &&
                 crt_index_q == vga_ext_pkg::IDX_UP_UNLOCK) begin
      rd_hit_d = 1'b1;
      rdata_d = o_upper_rd_en ? upper_unlock_reg_q
                              : vga_ext_pkg::PROTECTED_READ;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= vga_ext_pkg::RESET_VALUE;
      o_rdata_hit <= 1'b0;
    end else begin
      o_rdata <= rdata_d;
      o_rdata_hit <= rd_hit_d;
    end
  end

  // write-enable mask for the crt datapath, evaluated per write
  // per-bit lock mask
  always_comb begin
    o_crt_wmask = 8'hFF;
    if (crt_index_q <= vga_ext_pkg::CRT_H_LAST) begin
      if (crt_lock_reg_q[vga_ext_pkg::CL_HLOCK] || i_crt_protect) begin
        o_crt_wmask = 8'h00;
      end
    end else if (crt_index_q == vga_ext_pkg::CRT_VTOTAL) begin
      if (crt_lock_reg_q[vga_ext_pkg::CL_VLOCK] || i_crt_protect) begin
        o_crt_wmask = 8'h00;
      end
    end else if (crt_index_q == vga_ext_pkg::CRT_OVERFLOW) begin
      if (!crt_lock_reg_q[vga_ext_pkg::CL_G1_OPEN] && i_crt_protect) begin
        o_crt_wmask = o_crt_wmask & ~vga_ext_pkg::OVF_GRP1_MASK;
      end
      if (crt_lock_reg_q[vga_ext_pkg::CL_VLOCK] || i_crt_protect) begin
        o_crt_wmask = o_crt_wmask & ~vga_ext_pkg::OVF_GRP2_MASK;
      end
    end else if (crt_index_q == vga_ext_pkg::CRT_MAX_SCAN) begin
      if (crt_lock_reg_q[vga_ext_pkg::CL_VLOCK]) begin
        o_crt_wmask = ~vga_ext_pkg::MSL_GRP3_MASK;
      end
    end else if (crt_index_q == vga_ext_pkg::CRT_VRS ||
                 crt_index_q == vga_ext_pkg::CRT_SVB ||
                 crt_index_q == vga_ext_pkg::CRT_EVB) begin
      if (crt_lock_reg_q[vga_ext_pkg::CL_VLOCK]) begin
        o_crt_wmask = 8'h00;
      end
    end else if (crt_index_q == vga_ext_pkg::CRT_VRE) begin
      if (crt_lock_reg_q[vga_ext_pkg::CL_VLOCK]) begin
        o_crt_wmask = ~vga_ext_pkg::VRE_GRP3_MASK;
      end
    end else if (crt_index_q == vga_ext_pkg::CRT_MODE) begin
      if (crt_lock_reg_q[vga_ext_pkg::CL_HLOCK]) begin
        o_crt_wmask = ~vga_ext_pkg::MODE_GRP4_MASK;
      end
    end
  end

  assign o_misc_wmask = ~{crt_lock_reg_q[vga_ext_pkg::CL_VPOL],
                          crt_lock_reg_q[vga_ext_pkg::CL_HPOL], 6'h00};

  always_comb begin
    if (i_misc_ctrl2_std) begin
      o_mem_size = vga_ext_pkg::MEM_256_STD;
    end else begin
      case (memory_size_reg_q[vga_ext_pkg::MS_SIZE_HI:
                              vga_ext_pkg::MS_SIZE_LO])
        2'h0: o_mem_size = vga_ext_pkg::MEM_256_STD;
        2'h1: o_mem_size = vga_ext_pkg::MEM_256_EXT;
        2'h2: o_mem_size = vga_ext_pkg::MEM_512;
        default: o_mem_size = vga_ext_pkg::MEM_1024;
      endcase
    end
  end

  always_comb begin
    case (memory_size_reg_q[vga_ext_pkg::MS_MAP_HI:vga_ext_pkg::MS_MAP_LO])
      2'h0: o_mem_map = vga_ext_pkg::MAP_A0000_64K;
      2'h1: o_mem_map = vga_ext_pkg::MAP_256K_LOW;
      2'h2: o_mem_map = vga_ext_pkg::MAP_512K_LOW;
      default: o_mem_map = vga_ext_pkg::MAP_1M_UP;
    endcase
  end

  assign o_alt_offset_en = memory_size_reg_q[vga_ext_pkg::MS_ALT_OFS];
  assign o_host_16bit = memory_size_reg_q[vga_ext_pkg::MS_HOST16];
  assign o_rom_16bit = memory_size_reg_q[vga_ext_pkg::MS_ROM16];

  // address bit 0 selection; chained page select wins over word mode for the host address only, crt address ignores chaining
  always_comb begin
    o_host_ma0 = i_host_addr[0];
    o_crt_ma0 = i_char_address_counter[0];
    if (|i_graphics_misc_chain) begin
      o_host_ma0 = !i_misc_out_page;
    end else if (i_word_mode) begin
      if (o_mem_size == vga_ext_pkg::MEM_1024) begin
        o_host_ma0 = i_host_addr[18];
      end else begin
        o_host_ma0 = i_host_addr[16];
      end
    end
    if (i_word_mode) begin
      if (o_mem_size == vga_ext_pkg::MEM_1024) begin
        o_crt_ma0 = i_char_address_counter[17];
      end else begin
        o_crt_ma0 = i_char_address_counter[15];
      end
    end
  end

  assign o_alt_pc_display_mode = video_select_reg_q[vga_ext_pkg::VS_ALT_PC];
  assign o_non_vga_crt = video_select_reg_q[vga_ext_pkg::VS_NON_VGA];
  assign o_char_width = i_graphics_mode ? 2'h0 :
      video_select_reg_q[vga_ext_pkg::VS_CW_HI:vga_ext_pkg::VS_CW_LO];
  assign o_clk_sel2 = cnf_sync_q[vga_ext_pkg::STRAP_CLK_OUT] &&
                      video_select_reg_q[vga_ext_pkg::VS_CLK_SEL2];
  assign o_clk_mux_freeze = !cnf_sync_q[vga_ext_pkg::STRAP_CLK_OUT] &&
                            video_select_reg_q[vga_ext_pkg::VS_CLK_SEL2];
  assign o_hclk_8_9 = video_select_reg_q[vga_ext_pkg::VS_HCLK_HI];
  assign o_start_addr_hi = {crt_lock_reg_q[vga_ext_pkg::CL_SA9],
                            crt_lock_reg_q[vga_ext_pkg::CL_SA8]};
  assign o_display_enable_mode = video_output_ctrl_reg_q[vga_ext_pkg::VO_DE];
  assign o_pclk_is_video_clock_in = video_output_ctrl_reg_q[vga_ext_pkg::VO_PCLK];
  assign o_video_oe = !video_output_ctrl_reg_q[vga_ext_pkg::VO_VID_TRI];
  assign o_mem_oe = !video_output_ctrl_reg_q[vga_ext_pkg::VO_MEM_TRI];
  assign o_legacy_compat = video_output_ctrl_reg_q[vga_ext_pkg::VO_LEGACY];
  assign o_attr_write_only = o_legacy_compat;

  chk_lower_write_gate: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    i_gfx_data_wr && !lower_wr_ok && gfx_index_q == vga_ext_pkg::IDX_VID_SEL
    |=> $stable(video_select_reg_q))
    else $error("locked video select changed");
  chk_lower_write_take: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    i_gfx_data_wr && lower_wr_ok && gfx_index_q == vga_ext_pkg::IDX_VID_OUT
    |=> video_output_ctrl_reg_q == $past(i_wdata))
    else $error("unlocked write lost");
  chk_protected_read_ff: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    i_gfx_data_rd && !lower_rd_ok && gfx_index_q == vga_ext_pkg::IDX_MEM_SIZE
    |=> o_rdata == vga_ext_pkg::PROTECTED_READ && o_rdata_hit)
    else $error("protected read not FF");
  chk_upper_read_gate: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    i_crt_data_rd && crt_index_q == vga_ext_pkg::IDX_UP_UNLOCK &&
    !upper_unlock_reg_q[7]
    |=> o_rdata == vga_ext_pkg::PROTECTED_READ)
    else $error("upper unlock read not blocked");
  chk_hgroup_lock: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    crt_index_q <= vga_ext_pkg::CRT_H_LAST &&
    (crt_lock_reg_q[5] || i_crt_protect) |-> o_crt_wmask == 8'h00)
    else $error("horizontal group open while locked");
  chk_group3_no_protect: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    crt_index_q == vga_ext_pkg::CRT_VRS && !crt_lock_reg_q[0]
    |-> o_crt_wmask == 8'hFF)
    else $error("group three locked by protect bit");
  chk_overflow_split: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    crt_index_q == vga_ext_pkg::CRT_OVERFLOW && crt_lock_reg_q[1] &&
    i_crt_protect |-> o_crt_wmask == 8'h52)
    else $error("overflow mask wrong");
  chk_strap_invert: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    $rose(strap_stage_q[2]) |-> memory_size_reg_q[1:0] == ~$past(md_sync_q))
    else $error("strap not latched inverted");
  chk_page_select: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    |i_graphics_misc_chain |-> o_host_ma0 == !i_misc_out_page)
    else $error("page select not on address bit 0");
  chk_std_mapping: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    i_misc_ctrl2_std |-> o_mem_size == vga_ext_pkg::MEM_256_STD)
    else $error("standard mapping not forced");
  cov_unlock_then_write: cover property (@(posedge i_mclk)
    disable iff (!i_reset_n) !lower_wr_ok ##1 lower_wr_ok ##[1:4] gfx_wr);
  cov_upper_read: cover property (@(posedge i_mclk)
    disable iff (!i_reset_n) o_upper_rd_en && rd_hit_d && i_crt_data_rd);
  cov_locked_overflow: cover property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    i_crt_data_wr && crt_index_q == vga_ext_pkg::CRT_OVERFLOW &&
    o_crt_wmask != 8'hFF);
endmodule // vga_ext_regs

// >>> include/vga_ext_pkg.sv
// constants for the extension configuration and locking register bank
package vga_ext_pkg;
  localparam logic [7:0] IDX_MEM_SIZE = 8'h0B;
  localparam logic [7:0] IDX_VID_SEL = 8'h0C;
  localparam logic [7:0] IDX_CRT_LOCK = 8'h0D;
  localparam logic [7:0] IDX_VID_OUT = 8'h0E;
  localparam logic [7:0] IDX_LOW_UNLOCK = 8'h0F;
  localparam logic [7:0] IDX_UP_UNLOCK = 8'h29;
  localparam logic [7:0] IDX_UP_LAST = 8'h30;
  // crt register indices touched by group locks
  localparam logic [7:0] CRT_H_LAST = 8'h05;
  localparam logic [7:0] CRT_VTOTAL = 8'h06;
  localparam logic [7:0] CRT_OVERFLOW = 8'h07;
  localparam logic [7:0] CRT_MAX_SCAN = 8'h09;
  localparam logic [7:0] CRT_VRS = 8'h10;
  localparam logic [7:0] CRT_VRE = 8'h11;
  localparam logic [7:0] CRT_SVB = 8'h15;
  localparam logic [7:0] CRT_EVB = 8'h16;
  localparam logic [7:0] CRT_MODE = 8'h17;
  // bit masks inside the locked crt registers and the misc register
  localparam logic [7:0] OVF_GRP1_MASK = 8'h42;
  localparam logic [7:0] OVF_GRP2_MASK = 8'hAD;
  localparam logic [7:0] MSL_GRP3_MASK = 8'h20;
  localparam logic [7:0] VRE_GRP3_MASK = 8'h0F;
  localparam logic [7:0] MODE_GRP4_MASK = 8'h04;
  localparam logic [7:0] MISC_SYNC_MASK = 8'hC0;
  // unlock codes
  localparam logic [2:0] UNLOCK_CODE = 3'h5;
  localparam int RD_EN_BIT = 7;
  localparam int RD_BLK_BIT = 3;
  localparam logic [7:0] PROTECTED_READ = 8'hFF;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // field positions
  localparam int MS_SIZE_HI = 7;
  localparam int MS_SIZE_LO = 6;
  localparam int MS_MAP_HI = 5;
  localparam int MS_MAP_LO = 4;
  localparam int MS_ALT_OFS = 3;
  localparam int MS_HOST16 = 2;
  localparam int MS_ROM16 = 1;
  localparam int VS_ALT_PC = 7;
  localparam int VS_NON_VGA = 6;
  localparam int VS_CW_HI = 4;
  localparam int VS_CW_LO = 3;
  localparam int VS_CLK_SEL2 = 1;
  localparam int VS_HCLK_HI = 0;
  localparam int CL_VPOL = 7;
  localparam int CL_HPOL = 6;
  localparam int CL_HLOCK = 5;
  localparam int CL_SA9 = 4;
  localparam int CL_SA8 = 3;
  localparam int CL_G1_OPEN = 1;
  localparam int CL_VLOCK = 0;
  localparam int VO_DE = 7;
  localparam int VO_PCLK = 6;
  localparam int VO_VID_TRI = 5;
  localparam int VO_MEM_TRI = 4;
  localparam int VO_LEGACY = 1;
  localparam int STRAP_CLK_OUT = 3;
  localparam int STRAP_W = 9;
  typedef enum logic [3:0] {
    MEM_256_STD = 4'b0001,
    MEM_256_EXT = 4'b0010,
    MEM_512 = 4'b0100,
    MEM_1024 = 4'b1000
  } mem_size_t;
  typedef enum logic [3:0] {
    MAP_A0000_64K = 4'b0001,
    MAP_256K_LOW = 4'b0010,
    MAP_512K_LOW = 4'b0100,
    MAP_1M_UP = 4'b1000
  } mem_map_t;
endpackage
